// File: design/ltc_coef_mem.sv
// Small coefficient store with registered read data
`timescale 1ns/100ps
module ltc_coef_mem #(
   parameter int DEPTH = 4,
   parameter logic [31:0] INIT = 32'h0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [31:0] wdata,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [DEPTH];
   logic [31:0] next_rdata;
   initial begin
      if (DEPTH < 2) $error("DEPTH must be at least 2");
   end
   always_comb begin
      next_rdata = mem[raddr];
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata <= 32'h0000_0000;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= INIT;
         end
      end else begin
         rdata <= next_rdata;
         if (we) begin
            mem[waddr] <= wdata;
         end
      end
   end
endmodule : ltc_coef_mem

// File: design/ltc_pkg.sv
// Package: register map, field layout, reset values and timing for loop tuning control
package ltc_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_ONOFF = 8'h00;
   localparam logic [7:0] ADDR_TUNE = 8'h04;
   localparam logic [7:0] ADDR_GAIN = 8'h08;
   localparam logic [7:0] ADDR_CMD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_COEF0 = 8'h20;
   localparam logic [7:0] ADDR_NVM0 = 8'h40;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CMD_TRIG_BIT = 0;
   localparam int CMD_STORE_BIT = 1;
   localparam logic [1:0] ONOFF_RST = 2'h0;
   localparam logic [7:0] GAIN_RST = 8'h32;
   localparam logic [7:0] GAIN_MIN = 8'h0A;
   localparam logic [7:0] GAIN_MAX = 8'h64;
   localparam logic [31:0] SAFE_COEF = 32'h0000_1000;
   localparam logic [31:0] NVM_COEF_RST = 32'h0000_0800;
   // ----------------------------------------
   // Times and cycle counts at 100 MHz
   // ----------------------------------------
   localparam longint CLK_HZ = 100_000_000;
   localparam longint TUNE_MIN_MS = 50;
   localparam longint TUNE_MAX_MS = 200;
   localparam longint PERIOD_SEC_S = 1;
   localparam longint PERIOD_MIN_S = 60;
   localparam longint TUNE_MIN_CYC = TUNE_MIN_MS * CLK_HZ / 1000;
   localparam longint TUNE_MAX_CYC = TUNE_MAX_MS * CLK_HZ / 1000;
   localparam longint SEC_CYC = PERIOD_SEC_S * CLK_HZ;
   localparam longint MIN_CYC = PERIOD_MIN_S * CLK_HZ;
   localparam int RAMP_CYC = 1000;
   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      ONOFF_PIN = 2'h0,
      ONOFF_ALWAYS = 2'h1,
      ONOFF_BUS = 2'h2
   } ltc_onoff_t;
   typedef enum logic [1:0] {
      TM_DISABLED = 2'h0,
      TM_ONCE = 2'h1,
      TM_SECOND = 2'h2,
      TM_MINUTE = 2'h3
   } ltc_tmode_t;
   localparam logic [1:0] TMODE_RST = 2'h1;
   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_RAMP = 4'b0010,
      ST_TUNE = 4'b0100,
      ST_RUN = 4'b1000
   } ltc_state_t;
endpackage : ltc_pkg

// File: design/ltc_top.sv
// Top: on/off control, tuning scheduler, coefficient memories and AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Operation
// - Pin open enables, pin grounded disables output
// - Always-on or bus-commanded on/off modes
// - Compensator coefficients writable over the bus
// - Tune after ramp completes, apply result
// - Tuning run lasts 50 to 200 ms
// - Modes disabled, once, every second, minute
// - Optionally tune only after first ramp
// - Manual trigger command starts a run
// - Gain 10 to 100 percent, default 50
// - Working set filled from stores at power-up
// - Tuning enabled loads safe set at power-up
// - Tuned result written into working memory word 0, or into a same-cycle bus write's word; a same-cycle load copy drops it
// - Store saves whole working memory to user
// - Disabled to enabled loads safe set
// - Enabled to disabled reloads user store
// - Tuning disabled loads user store at power-up
module ltc_top #(
   parameter int NCOEF = 4,
   parameter int TUNE_CYC = 10_000_000,
   parameter longint SEC_PERIOD = ltc_pkg::SEC_CYC,
   parameter longint MIN_PERIOD = ltc_pkg::MIN_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter pins
   input wire logic remote_onoff,
   input wire logic [31:0] plant_measure,
   output logic output_enable,
   output logic tuning_active,
   output logic [31:0] active_coef
);
   import ltc_pkg::*;
   localparam int AW = $clog2(NCOEF);
   initial begin
      if (NCOEF < 2 || NCOEF > 8) $error("NCOEF must be 2..8");
      if (TUNE_CYC < TUNE_MIN_CYC || TUNE_CYC > TUNE_MAX_CYC) $error("TUNE_CYC outside run window");
   end
   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   logic pin_s1, pin_s2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         pin_s1 <= remote_onoff;
         pin_s2 <= pin_s1;
      end
   end
   // ----------------------------------------
   // Registers and bus slave
   // ----------------------------------------
   logic [1:0] onoff_mode, next_onoff_mode;
   logic bus_on, next_bus_on;
   logic [1:0] tmode, next_tmode;
   logic first_only, next_first_only;
   logic [7:0] gain, next_gain;
   logic trig, next_trig;
   logic store, next_store;
   logic aw_hold, next_aw_hold;
   logic w_hold, next_w_hold;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic bus_we;
   logic [AW-1:0] bus_widx;
   logic [31:0] ram_rd, nvm_rd;
   logic [AW-1:0] ram_raddr;
   logic rd_pend, next_rd_pend;
   logic [7:0] rd_addr, next_rd_addr;
   logic [3:0] state;
   logic tune_busy, tune_done;
   logic [31:0] tune_result;

   function automatic logic is_coef(input logic [7:0] a, input logic [7:0] base);
      return (a >= base) && (a < base + 8'(NCOEF * 4));
   endfunction : is_coef

   always_comb begin
      next_onoff_mode = onoff_mode;
      next_bus_on = bus_on;
      next_tmode = tmode;
      next_first_only = first_only;
      next_gain = gain;
      next_trig = 1'b0;
      next_store = 1'b0;
      next_aw_hold = aw_hold;
      next_w_hold = w_hold;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_awready = 1'b0;
      next_wready = 1'b0;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_arready = 1'b0;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_rd_pend = 1'b0;
      next_rd_addr = rd_addr;
      bus_we = 1'b0;
      bus_widx = aw_addr[AW+1:2];
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      next_awready = !next_aw_hold && !s_axi_bvalid && !s_axi_awready;
      next_wready = !next_w_hold && !s_axi_bvalid && !s_axi_wready;
      if (aw_hold && w_hold && !s_axi_bvalid) begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = 2'h0;
         if (w_strb[0]) begin
            unique case (aw_addr)
               ADDR_ONOFF: begin
                  next_onoff_mode = w_data[1:0];
                  next_bus_on = w_data[4];
               end
               ADDR_TUNE: begin
                  next_tmode = w_data[1:0];
                  next_first_only = w_data[4];
               end
               ADDR_GAIN: begin
                  if (w_data[7:0] >= GAIN_MIN && w_data[7:0] <= GAIN_MAX) begin
                     next_gain = w_data[7:0];
                  end else begin
                     next_bresp = 2'h2;
                  end
               end
               ADDR_CMD: begin
                  next_trig = w_data[CMD_TRIG_BIT];
                  next_store = w_data[CMD_STORE_BIT];
               end
               default: begin
                  if (is_coef(aw_addr, ADDR_COEF0)) begin
                     bus_we = 1'b1;
                  end else begin
                     next_bresp = 2'h2;
                  end
               end
            endcase
         end
      end
      // Reads take two cycles so coefficient data leaves the memory register
      if (s_axi_arvalid && s_axi_arready) begin
         next_rd_pend = 1'b1;
         next_rd_addr = s_axi_araddr;
      end
      next_arready = !s_axi_arready && !rd_pend && !s_axi_rvalid && !next_rvalid;
      if (rd_pend) begin
         next_rvalid = 1'b1;
         next_rresp = 2'h0;
         unique case (rd_addr)
            ADDR_ONOFF: next_rdata = {27'h0, bus_on, 2'h0, onoff_mode};
            ADDR_TUNE: next_rdata = {27'h0, first_only, 2'h0, tmode};
            ADDR_GAIN: next_rdata = {24'h0, gain};
            ADDR_CMD: next_rdata = 32'h0000_0000;
            ADDR_STATUS: next_rdata = {26'h0, tune_busy, output_enable, state};
            default: begin
               if (is_coef(rd_addr, ADDR_COEF0)) begin
                  next_rdata = ram_rd;
               end else if (is_coef(rd_addr, ADDR_NVM0)) begin
                  next_rdata = nvm_rd;
               end else begin
                  next_rdata = 32'h0000_0000;
                  next_rresp = 2'h2;
               end
            end
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         onoff_mode <= ONOFF_RST;
         bus_on <= 1'b0;
         tmode <= TMODE_RST;
         first_only <= 1'b0;
         gain <= GAIN_RST;
         trig <= 1'b0;
         store <= 1'b0;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         rd_pend <= 1'b0;
         rd_addr <= 8'h00;
      end else begin
         onoff_mode <= next_onoff_mode;
         bus_on <= next_bus_on;
         tmode <= next_tmode;
         first_only <= next_first_only;
         gain <= next_gain;
         trig <= next_trig;
         store <= next_store;
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         rd_pend <= next_rd_pend;
         rd_addr <= next_rd_addr;
      end
   end
   // ----------------------------------------
   // Output control and tuning sequencer
   // ----------------------------------------
   ltc_state_t st, next_st;
   logic want_on;
   logic [31:0] ramp_cnt, next_ramp_cnt;
   logic [39:0] per_cnt, next_per_cnt;
   logic tuned_once, next_tuned_once;
   logic [1:0] prev_tmode;
   logic [2:0] load_step, next_load_step;
   logic load_safe, load_user, next_load_safe, next_load_user;
   logic tune_start;
   logic [39:0] period;
   assign state = st;
   // Pin mode follows the pulled-up pin: open is on, grounded is off
   assign want_on = (onoff_mode == ONOFF_ALWAYS) || (onoff_mode == ONOFF_BUS && bus_on) ||
                    (onoff_mode == ONOFF_PIN && pin_s2);
   assign period = (tmode == TM_SECOND) ? 40'(SEC_PERIOD) : 40'(MIN_PERIOD);
   always_comb begin
      next_st = st;
      next_ramp_cnt = ramp_cnt;
      next_per_cnt = per_cnt;
      next_tuned_once = tuned_once;
      tune_start = 1'b0;
      unique case (st)
         ST_OFF: if (want_on) begin
            next_st = ST_RAMP;
            next_ramp_cnt = 32'h0000_0000;
         end
         ST_RAMP: begin
            next_ramp_cnt = ramp_cnt + 32'h0000_0001;
            if (!want_on) next_st = ST_OFF;
            else if (ramp_cnt == 32'(RAMP_CYC - 1)) begin
               // Tune after the ramp unless disabled or first-only already done
               if (tmode != TM_DISABLED && !(first_only && tuned_once)) begin
                  next_st = ST_TUNE;
                  tune_start = 1'b1;
               end else next_st = ST_RUN;
            end
         end
         ST_TUNE: begin
            if (!want_on) next_st = ST_OFF;
            else if (tune_done) begin
               next_st = ST_RUN;
               next_tuned_once = 1'b1;
               next_per_cnt = 40'h00_0000_0000;
            end
         end
         ST_RUN: begin
            next_per_cnt = per_cnt + 40'h00_0000_0001;
            if (!want_on) next_st = ST_OFF;
            else if (trig || ((tmode == TM_SECOND || tmode == TM_MINUTE) &&
                              per_cnt >= period - 40'h00_0000_0001)) begin
               next_st = ST_TUNE;
               tune_start = 1'b1;
            end
         end
      endcase
   end
   // Coefficient reload control: power-up and tuning-mode changes
   always_comb begin
      next_load_step = load_step;
      next_load_safe = 1'b0;
      next_load_user = 1'b0;
      if (load_step != 3'h0) begin
         next_load_step = load_step + 3'h1;
         if (load_step == 3'h3) begin
            next_load_safe = (tmode != TM_DISABLED);
            next_load_user = (tmode == TM_DISABLED);
            next_load_step = 3'h0;
         end
      end else if (prev_tmode == TM_DISABLED && tmode != TM_DISABLED) begin
         next_load_safe = 1'b1;
      end else if (prev_tmode != TM_DISABLED && tmode == TM_DISABLED) begin
         next_load_user = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= ST_OFF;
         ramp_cnt <= 32'h0000_0000;
         per_cnt <= 40'h00_0000_0000;
         tuned_once <= 1'b0;
         prev_tmode <= TMODE_RST;
         load_step <= 3'h1;
         load_safe <= 1'b0;
         load_user <= 1'b0;
         output_enable <= 1'b0;
         tuning_active <= 1'b0;
      end else begin
         st <= next_st;
         ramp_cnt <= next_ramp_cnt;
         per_cnt <= next_per_cnt;
         tuned_once <= next_tuned_once;
         prev_tmode <= tmode;
         load_step <= next_load_step;
         load_safe <= next_load_safe;
         load_user <= next_load_user;
         output_enable <= (next_st != ST_OFF);
         tuning_active <= (next_st == ST_TUNE);
      end
   end
   // ----------------------------------------
   // Working and user coefficient memories
   // ----------------------------------------
   // Multi-cycle copy walks index by index; bus writes meanwhile may be overwritten
   logic [AW:0] cp_idx, next_cp_idx;
   logic [1:0] cp_kind, next_cp_kind; // 1 safe, 2 user, 3 store
   logic cp_we, nvm_we;
   logic [AW-1:0] cp_rd, cp_wr;
   logic [31:0] ram_wd;
   always_comb begin
      next_cp_idx = cp_idx;
      next_cp_kind = cp_kind;
      if (cp_kind == 2'h0) begin
         next_cp_idx = '0;
         if (load_safe) next_cp_kind = 2'h1;
         else if (load_user) next_cp_kind = 2'h2;
         else if (store) next_cp_kind = 2'h3;
      end else begin
         next_cp_idx = cp_idx + 1'b1;
         if (cp_idx == (AW+1)'(NCOEF)) next_cp_kind = 2'h0;
      end
   end
   assign cp_rd = cp_idx[AW-1:0];
   assign cp_wr = AW'(cp_idx - 1'b1);
   assign cp_we = (cp_idx != '0) && (cp_kind == 2'h1 || cp_kind == 2'h2);
   assign nvm_we = (cp_idx != '0) && (cp_kind == 2'h3);
   // Read index goes in at the handshake so the registered word stands while the read is pending;
   // a read taken during a copy returns the copy's word instead
   assign ram_raddr = (cp_kind != 2'h0) ? cp_rd :
                      ((s_axi_arvalid && s_axi_arready) ? AW'(s_axi_araddr[AW+1:2]) : '0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cp_idx <= '0;
         cp_kind <= 2'h0;
         active_coef <= 32'h0000_0000;
      end else begin
         cp_idx <= next_cp_idx;
         cp_kind <= next_cp_kind;
         active_coef <= (cp_kind == 2'h0 && !rd_pend) ? ram_rd : active_coef;
      end
   end
   always_comb begin
      ram_wd = w_data;
      if (cp_we) ram_wd = (cp_kind == 2'h1) ? SAFE_COEF : nvm_rd;
      else if (tune_done && st == ST_TUNE) ram_wd = tune_result;
   end
   ltc_coef_mem #(.DEPTH(NCOEF), .INIT(SAFE_COEF)) u_ram (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(cp_we || bus_we || (tune_done && st == ST_TUNE && want_on)),
      .waddr(cp_we ? cp_wr : (bus_we ? bus_widx : '0)),
      .wdata(ram_wd),
      .raddr(ram_raddr),
      .rdata(ram_rd)
   );
   ltc_coef_mem #(.DEPTH(NCOEF), .INIT(NVM_COEF_RST)) u_nvm (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(nvm_we),
      .waddr(cp_wr),
      .wdata(ram_rd),
      .raddr(ram_raddr),
      .rdata(nvm_rd)
   );
   ltc_tuner #(.RUN_CYC(TUNE_CYC)) u_tuner (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(tune_start),
      .abort(st == ST_TUNE && !want_on),
      .gain(gain),
      .measured(plant_measure),
      .busy(tune_busy),
      .done(tune_done),
      .result(tune_result)
   );
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_pin_ground_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (onoff_mode == ONOFF_PIN && !pin_s2) |=> !output_enable)
      else $error("output on with pin grounded");
   a_always_on: assert property (@(posedge aclk) disable iff (!aresetn)
      (onoff_mode == ONOFF_ALWAYS) |=> output_enable)
      else $error("always-on mode not on");
   a_gain_range: assert property (@(posedge aclk) disable iff (!aresetn)
      gain >= GAIN_MIN && gain <= GAIN_MAX)
      else $error("gain out of range");
   a_ramp_tune: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == ST_RAMP && ramp_cnt == 32'(RAMP_CYC - 1) && want_on && tmode != TM_DISABLED && !first_only)
      |=> st == ST_TUNE)
      else $error("no tuning after ramp");
   a_off_abandon: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == ST_TUNE && !want_on) |=> (st == ST_OFF) ##1 !tune_busy)
      else $error("run not abandoned");
   a_trig_start: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == ST_RUN && trig && want_on) |=> tuning_active)
      else $error("manual trigger ignored");
   a_disable_user: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(tmode) != TM_DISABLED && tmode == TM_DISABLED && load_step == 3'h0) |=> load_user)
      else $error("no user reload on disable");
   a_enable_safe: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(tmode) == TM_DISABLED && tmode != TM_DISABLED && load_step == 3'h0) |=> load_safe)
      else $error("no safe load on enable");
endmodule : ltc_top

// File: design/ltc_tuner.sv
// Tuning engine: measures a run and returns one gain-scaled coefficient
`timescale 1ns/100ps
module ltc_tuner #(
   parameter int RUN_CYC = 5_000_000
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic [7:0] gain,
   input wire logic [31:0] measured,
   // Result
   output logic busy,
   output logic done,
   output logic [31:0] result
);
   import ltc_pkg::*;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic next_busy;
   logic next_done;
   logic [31:0] next_result;
   logic [39:0] prod;
   initial begin
      if (RUN_CYC < 1) $error("RUN_CYC must be positive");
   end
   always_comb begin
      next_cnt = cnt;
      next_busy = busy;
      next_done = 1'b0;
      next_result = result;
      prod = 40'(measured) * 40'(gain);
      if (abort) begin
         next_busy = 1'b0;
         next_cnt = 32'h0000_0000;
      end else if (start && !busy) begin
         next_busy = 1'b1;
         next_cnt = 32'h0000_0000;
      end else if (busy) begin
         next_cnt = cnt + 32'h0000_0001;
         if (cnt == 32'(RUN_CYC - 1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            // Result scaled by gain percentage
            next_result = 32'(prod / 40'h64);
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 32'h0000_0000;
         busy <= 1'b0;
         done <= 1'b0;
         result <= 32'h0000_0000;
      end else begin
         cnt <= next_cnt;
         busy <= next_busy;
         done <= next_done;
         result <= next_result;
      end
   end
endmodule : ltc_tuner

// File: test/loop_tuning_enable_control_tb.sv
// Testbench: register access, on/off control and tuning abort
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %h %h", $time, a, b); end end
module loop_tuning_enable_control_tb;
   import ltc_pkg::*;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, gnd = 1, pin;
   logic [7:0] aa = 0, ra = 0;
   logic [31:0] wd = 0, rdat, ac;
   logic [1:0] br, rr;
   logic awr, wrd, bv, arr, rv, oe, ta;
   int bad_count = 0, comparisons = 0;
   always #5 aclk = ~aclk;
   ltc_switch_model ltc_switch_model_inst (.grounded(gnd), .remote_onoff(pin));
   ltc_top #(.SEC_PERIOD(2000)) ltc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ra), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .remote_onoff(pin), .plant_measure(32'h0000_0100), .output_enable(oe), .tuning_active(ta),
      .active_coef(ac));
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   // Address and data go up together; each drops once its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      aa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv);
      bre <= 1'b0;
      `CHK(br, er)
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      ra <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rre <= 1'b0;
      `CHK(rdat, ed)
      `CHK(rr, er)
   endtask : rd
   task automatic wrap_up;
      $display("compares %0d bad %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   // Whole run is near 5400 cycles; the limit leaves ample slack
   initial begin
      #150us;
      bad_count++;
      wrap_up();
   end
   initial begin
      cyc(4);
      aresetn <= 1'b1;
      cyc(20);
      `CHK(oe, 1'b0)
      rd(ADDR_GAIN, 32'h32);
      rd(ADDR_COEF0, SAFE_COEF);
      rd(ADDR_NVM0, NVM_COEF_RST);
      rd(8'hFC, 32'h0, 2'h2);
      wr(ADDR_GAIN, 32'h09, 2'h2);
      wr(ADDR_GAIN, 32'h65, 2'h2);
      rd(ADDR_GAIN, 32'h32);
      wr(ADDR_GAIN, 32'h0A);
      rd(ADDR_GAIN, 32'h0A);
      wr(ADDR_ONOFF, 32'h01);
      cyc(10);
      `CHK(oe, 1'b1)
      wr(ADDR_ONOFF, 32'h02);
      cyc(10);
      `CHK(oe, 1'b0)
      wr(ADDR_ONOFF, 32'h12);
      cyc(10);
      `CHK(oe, 1'b1)
      wr(ADDR_ONOFF, 32'h00);
      cyc(10);
      `CHK(oe, 1'b0)
      wr(ADDR_TUNE, 32'h00);
      cyc(20);
      rd(ADDR_COEF0, NVM_COEF_RST);
      `CHK(ac, NVM_COEF_RST)
      wr(ADDR_TUNE, 32'h01);
      cyc(20);
      rd(ADDR_COEF0, SAFE_COEF);
      for (int m = 3; m >= 1; m--) begin
         wr(ADDR_TUNE, m);
         rd(ADDR_TUNE, m);
      end
      wr(ADDR_COEF0 + 8'h04, 32'h0ABC);
      rd(ADDR_COEF0 + 8'h04, 32'h0ABC);
      wr(ADDR_CMD, 32'h02);
      cyc(20);
      rd(ADDR_NVM0 + 8'h04, 32'h0ABC);
      rd(ADDR_NVM0, SAFE_COEF);
      gnd <= 1'b0;
      cyc(10);
      `CHK(oe, 1'b1)
      cyc(RAMP_CYC + 20);
      `CHK(ta, 1'b1)
      gnd <= 1'b1;
      cyc(10);
      `CHK({oe, ta}, 2'b00)
      rd(ADDR_COEF0, SAFE_COEF);
      wr(ADDR_TUNE, 32'h00);
      wr(ADDR_ONOFF, 32'h01);
      cyc(RAMP_CYC + 20);
      rd(ADDR_STATUS, 32'h18);
      `CHK(ta, 1'b0)
      wr(ADDR_CMD, 32'h01);
      cyc(4);
      rd(ADDR_STATUS, 32'h34);
      wr(ADDR_ONOFF, 32'h00);
      cyc(10);
      rd(ADDR_STATUS, 32'h01);
      wr(ADDR_ONOFF, 32'h01);
      cyc(RAMP_CYC + 20);
      wr(ADDR_TUNE, 32'h02);
      `CHK(ta, 1'b0)
      cyc(2000);
      `CHK(ta, 1'b1)
      wrap_up();
   end
endmodule : loop_tuning_enable_control_tb

// File: test/ltc_switch_model.sv
// Partner model: external on/off switch beside the pin pull-up
`timescale 1ns/100ps
module ltc_switch_model (
   // Switch
   input wire logic grounded,
   // Pin
   output logic remote_onoff
);
   // Switch only moves once any sync clock has settled; this bench runs none
   // An open switch leaves the pull-up holding the pin high
   assign remote_onoff = grounded ? 1'b0 : 1'b1;
endmodule : ltc_switch_model
